// >>> rtl/sale_pkg.sv
// Purpose: Shared constants and types of the switch address lookup engine
// Assumes: 20 MHz core clock, seven switch ports
// Notes:   Timing counts are derived from printed times and the clock rate
package sale_pkg;
	// --------------------------------------------------------------
	// Sizes
	// --------------------------------------------------------------
	localparam int NP       = 7;
	localparam int PW       = 3;
	localparam int BKT_N    = 1024;
	localparam int WAYS     = 4;
	localparam int IDX_W    = 10;
	localparam int ST_N     = 16;
	localparam int RSV_N    = 8;
	localparam int FB_BYTES = 262144;
	localparam int FB_WORDS = FB_BYTES / 4;
	localparam int FB_AW    = 16;
	// --------------------------------------------------------------
	// Hash selection and polynomial
	// --------------------------------------------------------------
	localparam logic [1:0]  HASH_DIRECT = 2'h0;
	localparam logic [1:0]  HASH_CRC    = 2'h1;
	localparam logic [1:0]  HASH_XOR    = 2'h2;
	localparam logic [1:0]  HASH_RST    = HASH_CRC;
	localparam logic [15:0] CRC_POLY    = 16'h1021;
	localparam logic [15:0] CRC_SEED    = 16'h0000;
	// --------------------------------------------------------------
	// Storm intervals
	// --------------------------------------------------------------
	localparam int CLK_HZ     = 20000000;
	localparam int T_1G_US    = 5000;
	localparam int T_100M_US  = 50000;
	localparam int T_10M_US   = 500000;
	localparam int CYC_1G     = T_1G_US * (CLK_HZ / 1000000);
	localparam int CYC_100M   = T_100M_US * (CLK_HZ / 1000000);
	localparam int CYC_10M    = T_10M_US * (CLK_HZ / 1000000);
	localparam int ICNT_W     = 24;
	localparam int BCNT_W     = 20;
	// Bytes per interval equal to 1 % of the link, same at every speed
	localparam logic [BCNT_W-1:0] STORM_RATE_RST = 20'h0186a;
	localparam logic [1:0] SPD_10M  = 2'h0;
	localparam logic [1:0] SPD_100M = 2'h1;
	localparam logic [1:0] SPD_1G   = 2'h2;
	// --------------------------------------------------------------
	// Reserved multicast group
	// --------------------------------------------------------------
	localparam logic [39:0] RSV_PREFIX = 40'h0180c20000;
	localparam logic [NP-1:0] FWD_HOST  = 7'h40;
	localparam logic [NP-1:0] FWD_NONE  = 7'h00;
	localparam logic [NP-1:0] FWD_ALL   = 7'h7f;
	localparam logic [NP-1:0] FWD_NOHST = 7'h3f;
	// --------------------------------------------------------------
	// Types
	// --------------------------------------------------------------
	typedef struct packed {
		logic          is_static;
		logic [6:0]    filtering_database_id;
		logic [47:0]   mac;
		logic [NP-1:0] ports;
	} sale_entry_t;

	typedef struct packed {
		logic [47:0]   da;
		logic [47:0]   sa;
		logic [6:0]    filtering_database_id;
		logic [PW-1:0] src;
		logic          err;
		logic          host_special;
	} sale_req_t;

	typedef struct packed {
		logic          drop;
		logic          hit;
		logic [NP-1:0] ports;
	} sale_res_t;
endpackage

// >>> rtl/sale_top.sv
// Purpose: Destination lookup, learning, frame store, storm limiter,
//          host port and self-address filter of the switch core
// Assumes: All inputs come from logic on the core clock
// Notes:   A lookup request is made only after the whole frame is stored
`timescale 1ns/10ps
`default_nettype none
module sale_top #(
	parameter int P_CYC_1G   = sale_pkg::CYC_1G,
	parameter int P_CYC_100M = sale_pkg::CYC_100M,
	parameter int P_CYC_10M  = sale_pkg::CYC_10M
) (
	input  wire logic                        i_clk,          // Core clock
	input  wire logic                        i_reset_n,      // Async reset
	input  wire logic                        i_vlan_en,      // VLAN operation
	input  wire logic [1:0]                  i_hash_sel,     // Index function
	input  wire logic                        i_rsv_en,       // Reserved table on
	input  wire logic [47:0]                 i_sw_mac,       // Switch address
	input  wire logic [sale_pkg::NP-1:0]     i_self_flt_en,  // Self filter
	input  wire logic [sale_pkg::NP-1:0]     i_tail_tag_en,  // Tail tagging
	input  wire logic                        i_rate_wr,      // Storm rate load
	input  wire logic [sale_pkg::BCNT_W-1:0] i_rate,         // Storm rate
	input  wire logic [sale_pkg::NP-1:0]     i_storm_en,     // Storm enable
	input  wire logic                        i_storm_mc,     // Count multicast
	input  wire logic [2*sale_pkg::NP-1:0]   i_speed,        // Link speeds
	input  wire logic [sale_pkg::NP-1:0]     i_rx_byte,      // Byte received
	input  wire logic [sale_pkg::NP-1:0]     i_rx_bc,        // Frame broadcast
	input  wire logic [sale_pkg::NP-1:0]     i_rx_mc,        // Frame multicast
	input  wire logic                        i_mt_wr,        // Main table write
	input  wire logic [sale_pkg::IDX_W-1:0]  i_mt_idx,       // Bucket index
	input  wire logic [1:0]                  i_mt_way,       // Way
	input  wire logic                        i_mt_vld,       // Entry valid
	input  wire sale_pkg::sale_entry_t       i_mt_ent,       // Entry
	input  wire logic                        i_st_wr,        // Static write
	input  wire logic [3:0]                  i_st_idx,       // Static index
	input  wire logic                        i_st_vld,       // Static valid
	input  wire sale_pkg::sale_entry_t       i_st_ent,       // Static entry
	input  wire logic                        i_learn,        // Learn request
	input  wire logic [47:0]                 i_learn_mac,    // Source address
	input  wire logic [6:0]                  i_learn_fid,    // Source id
	input  wire logic [sale_pkg::PW-1:0]     i_learn_port,   // Source port
	input  wire logic                        i_fb_wr,        // Buffer write
	input  wire logic [sale_pkg::FB_AW-1:0]  i_fb_waddr,     // Write address
	input  wire logic [31:0]                 i_fb_wdata,     // Write data
	input  wire logic [sale_pkg::FB_AW-1:0]  i_fb_raddr,     // Read address
	input  wire logic                        i_lk_req,       // Lookup request
	input  wire sale_pkg::sale_req_t         i_lk,           // Request fields
	output logic                             o_lk_valid,     // Result strobe
	output sale_pkg::sale_res_t              o_lk_res,       // Result
	output logic [31:0]                      o_fb_rdata,     // Buffer data
	output logic [sale_pkg::NP-1:0]          o_storm_over,   // Over rate
	output logic [sale_pkg::PW-1:0]          o_host_port,    // Host port
	output logic                             o_host_valid,   // Host exists
	output logic                             o_host_multi,   // Conflict
	output logic [47:0]                      o_pause_sa      // PAUSE source
);
	// ------------------------------------------------------------------
	// Index function
	// ------------------------------------------------------------------
	function automatic logic [9:0] idx_f(input logic [47:0] mac,
			input logic [6:0] filtering_database_id, input logic [1:0] sel);
		logic [15:0] crc;
		logic [15:0] base;
		crc = sale_pkg::CRC_SEED;
		for (int i = 47; i >= 0; i--) begin
			if (crc[15] ^ mac[i]) begin
				crc = {crc[14:0], 1'b0} ^ sale_pkg::CRC_POLY;
			end else begin
				crc = {crc[14:0], 1'b0};
			end
		end
		if (sel == sale_pkg::HASH_CRC) begin
			base = crc;
		end else if (sel == sale_pkg::HASH_XOR) begin
			base = mac[47:32] ^ mac[31:16] ^ mac[15:0];
		end else begin
			base = mac[15:0];
		end
		// Sum wraps modulo 1024
		return base[9:0] + {3'h0, filtering_database_id};
	endfunction

	// ------------------------------------------------------------------
	// Tables
	// ------------------------------------------------------------------
	// Memories carry no reset; only the valid bits do
	sale_pkg::sale_entry_t main_tbl [0:sale_pkg::BKT_N-1][0:sale_pkg::WAYS-1];
	logic [sale_pkg::WAYS-1:0] main_vld_ff [0:sale_pkg::BKT_N-1];
	sale_pkg::sale_entry_t st_tbl [0:sale_pkg::ST_N-1];
	logic [sale_pkg::ST_N-1:0] st_vld_ff;
	logic [31:0] fbuf [0:sale_pkg::FB_WORDS-1];

	// ------------------------------------------------------------------
	// Lookup stage 1: bucket read
	// ------------------------------------------------------------------
	wire logic [6:0] lk_fid = i_vlan_en ? i_lk.filtering_database_id : 7'h00;
	wire logic [9:0] lk_idx = idx_f(i_lk.da, lk_fid, i_hash_sel);
	logic                      s1_vld_ff;
	sale_pkg::sale_req_t       s1_req_ff;
	sale_pkg::sale_entry_t     s1_bkt_ff [0:sale_pkg::WAYS-1];
	logic [sale_pkg::WAYS-1:0] s1_bv_ff;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s1_vld_ff <= 1'b0;
			s1_req_ff <= '0;
			s1_bv_ff  <= '0;
		end else begin
			s1_vld_ff     <= i_lk_req;
			s1_req_ff     <= i_lk;
			s1_req_ff.filtering_database_id <= lk_fid;
			s1_bv_ff      <= main_vld_ff[lk_idx];
		end
	end

	always_ff @(posedge i_clk) begin
		for (int w = 0; w < sale_pkg::WAYS; w++) begin
			s1_bkt_ff[w] <= main_tbl[lk_idx][w];
		end
	end

	// ------------------------------------------------------------------
	// Lookup stage 2: parallel compare and priority
	// ------------------------------------------------------------------
	logic [sale_pkg::WAYS-1:0] way_hit;
	logic [sale_pkg::ST_N-1:0] st_hit;
	logic                      mt_s_hit;
	logic                      mt_d_hit;
	logic [sale_pkg::NP-1:0]   mt_s_p;
	logic [sale_pkg::NP-1:0]   mt_d_p;
	logic [sale_pkg::NP-1:0]   st_p;

	always_comb begin
		mt_s_hit = 1'b0;
		mt_d_hit = 1'b0;
		mt_s_p   = '0;
		mt_d_p   = '0;
		st_p     = '0;
		for (int w = 0; w < sale_pkg::WAYS; w++) begin
			way_hit[w] = s1_bv_ff[w] && s1_bkt_ff[w].mac == s1_req_ff.da
				&& s1_bkt_ff[w].filtering_database_id == s1_req_ff.filtering_database_id;
			if (way_hit[w] && s1_bkt_ff[w].is_static) begin
				mt_s_hit = 1'b1;
				mt_s_p   = s1_bkt_ff[w].ports;
			end else if (way_hit[w]) begin
				mt_d_hit = 1'b1;
				mt_d_p   = s1_bkt_ff[w].ports;
			end
		end
		for (int s = 0; s < sale_pkg::ST_N; s++) begin
			st_hit[s] = st_vld_ff[s] && st_tbl[s].mac == s1_req_ff.da
				&& st_tbl[s].filtering_database_id == s1_req_ff.filtering_database_id;
			if (st_hit[s]) begin
				st_p = st_tbl[s].ports;
			end
		end
	end

	// Reserved multicast groups, decoded from the last address byte
	wire logic [7:0] da_lo   = s1_req_ff.da[7:0];
	wire logic       rsv_hit = i_rsv_en
		&& s1_req_ff.da[47:8] == sale_pkg::RSV_PREFIX
		&& da_lo <= 8'h2f;
	wire logic [sale_pkg::NP-1:0] rsv_p =
		(da_lo == 8'h00) ? sale_pkg::FWD_HOST :
		(da_lo == 8'h01) ? sale_pkg::FWD_NONE :
		(da_lo == 8'h03) ? sale_pkg::FWD_HOST :
		(da_lo == 8'h10) ? sale_pkg::FWD_ALL :
		(da_lo == 8'h20 || da_lo == 8'h21) ? sale_pkg::FWD_NOHST :
		(da_lo < 8'h10) ? sale_pkg::FWD_HOST : sale_pkg::FWD_NOHST;

	wire logic any_static = mt_s_hit || (|st_hit) || rsv_hit;
	wire logic [sale_pkg::NP-1:0] stat_p =
		mt_s_hit ? mt_s_p : (|st_hit) ? st_p : rsv_p;
	wire logic [sale_pkg::NP-1:0] src_bit =
		sale_pkg::NP'(1) << s1_req_ff.src;
	wire logic [sale_pkg::NP-1:0] host_bit =
		sale_pkg::NP'(1) << o_host_port;
	wire logic [sale_pkg::NP-1:0] look_p =
		any_static ? stat_p : mt_d_hit ? mt_d_p : ~src_bit;
	wire logic [sale_pkg::NP-1:0] fwd_p =
		(s1_req_ff.host_special && o_host_valid) ? host_bit : look_p;
	wire logic is_bc = &s1_req_ff.da;
	wire logic is_mc = s1_req_ff.da[40] && !is_bc;
	wire logic self_drop = i_self_flt_en[s1_req_ff.src]
		&& s1_req_ff.sa == i_sw_mac;
	wire logic storm_drop = o_storm_over[s1_req_ff.src]
		&& (is_bc || (is_mc && i_storm_mc));
	wire logic local_drop = (fwd_p & ~src_bit) == '0;

	sale_pkg::sale_res_t nxt_res;
	always_comb begin
		nxt_res.hit   = any_static || mt_d_hit;
		nxt_res.drop  = s1_req_ff.err || self_drop || storm_drop || local_drop;
		nxt_res.ports = nxt_res.drop ? '0 : (fwd_p & ~src_bit);
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_lk_valid <= 1'b0;
			o_lk_res   <= '0;
		end else begin
			o_lk_valid <= s1_vld_ff;
			o_lk_res   <= nxt_res;
		end
	end

	// ------------------------------------------------------------------
	// Learning: bucket read, then write into a free or dynamic way
	// ------------------------------------------------------------------
	wire logic [6:0] ln_fid = i_vlan_en ? i_learn_fid : 7'h00;
	wire logic [9:0] ln_idx = idx_f(i_learn_mac, ln_fid, i_hash_sel);
	logic                      l1_vld_ff;
	logic [9:0]                l1_idx_ff;
	logic [47:0]               l1_mac_ff;
	logic [6:0]                l1_fid_ff;
	logic [sale_pkg::PW-1:0]   l1_port_ff;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			l1_vld_ff  <= 1'b0;
			l1_idx_ff  <= '0;
			l1_mac_ff  <= '0;
			l1_fid_ff  <= '0;
			l1_port_ff <= '0;
		end else begin
			l1_vld_ff  <= i_learn;
			l1_idx_ff  <= ln_idx;
			l1_mac_ff  <= i_learn_mac;
			l1_fid_ff  <= ln_fid;
			l1_port_ff <= i_learn_port;
		end
	end

	logic       ln_do;
	logic [1:0] ln_way;
	always_comb begin
		ln_do  = 1'b0;
		ln_way = 2'h0;
		// Reverse scan so the lowest way wins; static ways never taken
		for (int w = sale_pkg::WAYS - 1; w >= 0; w--) begin
			if (!main_tbl[l1_idx_ff][w].is_static
					|| !main_vld_ff[l1_idx_ff][w]) begin
				ln_do  = 1'b1;
				ln_way = 2'(w);
			end
		end
		for (int w = sale_pkg::WAYS - 1; w >= 0; w--) begin
			if (!main_vld_ff[l1_idx_ff][w]) begin
				ln_way = 2'(w);
			end
		end
		for (int w = sale_pkg::WAYS - 1; w >= 0; w--) begin
			if (main_vld_ff[l1_idx_ff][w]
					&& main_tbl[l1_idx_ff][w].mac == l1_mac_ff
					&& main_tbl[l1_idx_ff][w].filtering_database_id == l1_fid_ff) begin
				ln_do  = !main_tbl[l1_idx_ff][w].is_static;
				ln_way = 2'(w);
			end
		end
	end

	sale_pkg::sale_entry_t ln_ent;
	always_comb begin
		ln_ent.is_static = 1'b0;
		ln_ent.filtering_database_id       = l1_fid_ff;
		ln_ent.mac       = l1_mac_ff;
		ln_ent.ports     = sale_pkg::NP'(1) << l1_port_ff;
	end
	// Software write has priority; a learn colliding with it is dropped
	wire logic ln_wr = l1_vld_ff && ln_do && !i_mt_wr;

	always_ff @(posedge i_clk) begin
		if (i_mt_wr) begin
			main_tbl[i_mt_idx][i_mt_way] <= i_mt_ent;
		end else if (ln_wr) begin
			main_tbl[l1_idx_ff][ln_way] <= ln_ent;
		end
		if (i_st_wr) begin
			st_tbl[i_st_idx] <= i_st_ent;
		end
		if (i_fb_wr) begin
			fbuf[i_fb_waddr] <= i_fb_wdata;
		end
		o_fb_rdata <= fbuf[i_fb_raddr];
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int b = 0; b < sale_pkg::BKT_N; b++) begin
				main_vld_ff[b] <= '0;
			end
			st_vld_ff <= '0;
		end else begin
			if (i_mt_wr) begin
				main_vld_ff[i_mt_idx][i_mt_way] <= i_mt_vld;
			end else if (ln_wr) begin
				main_vld_ff[l1_idx_ff][ln_way] <= 1'b1;
			end
			if (i_st_wr) begin
				st_vld_ff[i_st_idx] <= i_st_vld;
			end
		end
	end

	// ------------------------------------------------------------------
	// Storm limiter
	// ------------------------------------------------------------------
	logic [sale_pkg::BCNT_W-1:0] rate_ff;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rate_ff <= sale_pkg::STORM_RATE_RST;
		end else if (i_rate_wr) begin
			rate_ff <= i_rate;
		end
	end

	for (genvar p = 0; p < sale_pkg::NP; p++) begin : g_storm
		logic [sale_pkg::ICNT_W-1:0] icnt_ff;
		logic [sale_pkg::BCNT_W-1:0] bcnt_ff;
		wire logic [1:0] spd = i_speed[2*p+1:2*p];
		wire logic [sale_pkg::ICNT_W-1:0] ilen =
			(spd == sale_pkg::SPD_1G) ? sale_pkg::ICNT_W'(P_CYC_1G) :
			(spd == sale_pkg::SPD_100M) ? sale_pkg::ICNT_W'(P_CYC_100M) :
			sale_pkg::ICNT_W'(P_CYC_10M);
		wire logic start = icnt_ff == '0;
		wire logic cnt = i_rx_byte[p]
			&& (i_rx_bc[p] || (i_storm_mc && i_rx_mc[p]));
		wire logic [sale_pkg::BCNT_W-1:0] nxt_bcnt =
			start ? sale_pkg::BCNT_W'(cnt) :
			(cnt && !(&bcnt_ff)) ? bcnt_ff + 1'b1 : bcnt_ff;

		always_ff @(posedge i_clk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				icnt_ff         <= '0;
				bcnt_ff         <= '0;
				o_storm_over[p] <= 1'b0;
			end else begin
				icnt_ff         <= start ? ilen - 1'b1 : icnt_ff - 1'b1;
				bcnt_ff         <= nxt_bcnt;
				o_storm_over[p] <= i_storm_en[p] && nxt_bcnt > rate_ff;
			end
		end
	end

	// ------------------------------------------------------------------
	// Host port and PAUSE source
	// ------------------------------------------------------------------
	logic [sale_pkg::PW-1:0] host_sel;
	logic [sale_pkg::PW-1:0] host_cnt;
	always_comb begin
		host_sel = '0;
		host_cnt = '0;
		for (int p = 0; p < sale_pkg::NP; p++) begin
			if (i_tail_tag_en[p]) begin
				host_sel = sale_pkg::PW'(p);
				host_cnt = host_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_host_port  <= '0;
			o_host_valid <= 1'b0;
			o_host_multi <= 1'b0;
			o_pause_sa   <= '0;
		end else begin
			o_host_port  <= host_sel;
			o_host_valid <= |i_tail_tag_en;
			o_host_multi <= host_cnt > 3'h1;
			o_pause_sa   <= i_sw_mac;
		end
	end
endmodule
`default_nettype wire

// >>> dv/sale_assertions.sv
// Purpose: Port-level checks of the lookup engine
// Assumes: One core clock domain, async active-low reset
// Notes:   Bound to sale_top after the module
`timescale 1ns/10ps
`default_nettype none
module sale_assertions (
	input wire logic                i_clk,          // Core clock
	input wire logic                i_reset_n,      // Async reset
	input wire logic [47:0]         i_sw_mac,       // Own address
	input wire logic [6:0]          i_self_flt_en,  // Self filter
	input wire logic [6:0]          i_tail_tag_en,  // Tail tagging
	input wire logic [6:0]          i_storm_en,     // Storm enable
	input wire logic                i_lk_req,       // Lookup request
	input wire sale_pkg::sale_req_t i_lk,           // Request fields
	input wire logic                o_lk_valid,     // Result strobe
	input wire sale_pkg::sale_res_t o_lk_res,       // Result
	input wire logic [6:0]          o_storm_over,   // Over rate
	input wire logic                o_host_valid,   // Host exists
	input wire logic                o_host_multi,   // Conflict
	input wire logic [47:0]         o_pause_sa      // PAUSE source
);
	// --------------------------------------------------------------
	// Settling counter: registered copies lag inputs just after reset
	// --------------------------------------------------------------
	logic [1:0] age_ff;
	logic [1:0] nxt_age;
	assign nxt_age = (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			age_ff <= 2'h0;
		else
			age_ff <= nxt_age;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// --------------------------------------------------------------
	// Properties
	// --------------------------------------------------------------
	a_lk_answer_lat: assert property (i_lk_req |-> ##2 o_lk_valid)
		else $error("lookup answer not two cycles after request");
	a_lk_no_stray: assert property (o_lk_valid |-> $past(i_lk_req, 2))
		else $error("lookup answer without request");
	a_err_frame_drop: assert property (i_lk_req && i_lk.err |-> ##2 o_lk_res.drop)
		else $error("errored frame not dropped");
	a_self_addr_drop: assert property (i_lk_req && i_lk.sa == i_sw_mac &&
		i_self_flt_en[i_lk.src] |-> ##2 o_lk_res.drop) else $error("own address frame kept");
	a_drop_no_ports: assert property (o_lk_valid && o_lk_res.drop |-> o_lk_res.ports == 7'h00)
		else $error("dropped frame still has ports");
	a_host_flags: assert property (age_ff == 2'h3 && $stable(i_tail_tag_en) |->
		o_host_valid == (|i_tail_tag_en) && o_host_multi == !$onehot0(i_tail_tag_en))
		else $error("host port flags wrong");
	a_pause_source: assert property (age_ff == 2'h3 && $stable(i_sw_mac) |->
		o_pause_sa == i_sw_mac) else $error("pause source differs from own address");
	a_storm_gate: assert property ((o_storm_over & ~i_storm_en & ~$past(i_storm_en)) == 7'h00)
		else $error("storm flag on disabled port");
	c_drop: cover property (o_lk_valid && o_lk_res.drop);
	c_hit: cover property (o_lk_valid && o_lk_res.hit);
	c_storm: cover property (|o_storm_over);
	c_multi: cover property (o_host_multi);
endmodule
bind sale_top sale_assertions sale_assertions_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_sw_mac(i_sw_mac), .i_self_flt_en(i_self_flt_en), .i_tail_tag_en(i_tail_tag_en),
	.i_storm_en(i_storm_en), .i_lk_req(i_lk_req), .i_lk(i_lk), .o_lk_valid(o_lk_valid),
	.o_lk_res(o_lk_res), .o_storm_over(o_storm_over), .o_host_valid(o_host_valid),
	.o_host_multi(o_host_multi), .o_pause_sa(o_pause_sa));
`default_nettype wire

// >>> dv/sale_mac_model.sv
// Purpose: Receive MAC model feeding byte strobes and frame kind
// Assumes: One byte per core clock while a frame is in progress
// Notes:   Kind levels fall to idle between frames
`timescale 1ns/10ps
`default_nettype none
module sale_mac_model (
	input wire logic        i_clk,    // Core clock
	input wire logic        i_start,  // Begin a frame
	input wire logic [12:0] i_len,    // Frame bytes
	input wire logic        i_bc,     // Frame broadcast
	input wire logic        i_mc,     // Frame multicast
	output logic            o_byte,   // Byte strobe
	output logic            o_bc,     // Broadcast level
	output logic            o_mc,     // Multicast level
	output logic            o_busy    // Frame in progress
);
	logic [12:0] left_ff = 13'h0000;
	logic        bc_ff = 1'b0;
	logic        mc_ff = 1'b0;
	always @(posedge i_clk) begin
		if (i_start) begin
			left_ff <= i_len;
			bc_ff <= i_bc;
			mc_ff <= i_mc;
		end else if (left_ff != 13'h0000) begin
			left_ff <= left_ff - 13'h0001;
		end
	end
	assign o_byte = (left_ff != 13'h0000);
	assign o_busy = o_byte;
	assign o_bc = bc_ff & o_byte;
	assign o_mc = mc_ff & o_byte;
endmodule
`default_nettype wire

// >>> dv/tb_switch_address_lookup_engine.sv
// Purpose: Self-checking bench of the switch lookup engine
// Assumes: Short storm intervals set by parameter
// Notes:   Storm test runs first to align with the first interval
`timescale 1ns/10ps
`default_nettype none
module tb_switch_address_lookup_engine;
	logic clk, rst_n, vlan_en, rsv_en, rate_wr, storm_mc, mt_wr, st_wr, learn, fb_wr, lk_req;
	logic go, mbyte, mbc, mmc, busy, lk_v, host_v, host_m, mbc_req, mmc_req;
	logic [1:0]  hsel, mt_way;
	logic [2:0]  lport, hport;
	logic [3:0]  st_idx;
	logic [6:0]  selff, tail, storm_en, over, lfid;
	logic [9:0]  mt_idx;
	logic [12:0] mlen;
	logic [13:0] speed;
	logic [15:0] fwa, fra;
	logic [19:0] rate;
	logic [31:0] fwd, frd;
	logic [47:0] swmac, lmac, psa, m;
	sale_pkg::sale_entry_t ment, sent;
	sale_pkg::sale_req_t   lk;
	sale_pkg::sale_res_t   res;
	int error_cnt, comparisons;
	localparam logic [47:0] SA = 48'h020000000001;
	sale_top #(.P_CYC_1G(6400), .P_CYC_100M(12800), .P_CYC_10M(25600)) sale_top_inst (
		.i_clk(clk), .i_reset_n(rst_n), .i_vlan_en(vlan_en), .i_hash_sel(hsel), .i_rsv_en(rsv_en),
		.i_sw_mac(swmac), .i_self_flt_en(selff), .i_tail_tag_en(tail), .i_rate_wr(rate_wr),
		.i_rate(rate), .i_storm_en(storm_en), .i_storm_mc(storm_mc), .i_speed(speed),
		.i_rx_byte({5'h00, mbyte, mbyte}), .i_rx_bc({5'h00, mbc, mbc}), .i_rx_mc({5'h00, mmc, mmc}),
		.i_mt_wr(mt_wr), .i_mt_idx(mt_idx), .i_mt_way(mt_way), .i_mt_vld(1'b1), .i_mt_ent(ment),
		.i_st_wr(st_wr), .i_st_idx(st_idx), .i_st_vld(1'b1), .i_st_ent(sent), .i_learn(learn),
		.i_learn_mac(lmac), .i_learn_fid(lfid), .i_learn_port(lport), .i_fb_wr(fb_wr),
		.i_fb_waddr(fwa), .i_fb_wdata(fwd), .i_fb_raddr(fra), .i_lk_req(lk_req), .i_lk(lk),
		.o_lk_valid(lk_v), .o_lk_res(res), .o_fb_rdata(frd), .o_storm_over(over),
		.o_host_port(hport), .o_host_valid(host_v), .o_host_multi(host_m), .o_pause_sa(psa));
	sale_mac_model sale_mac_model_inst (.i_clk(clk), .i_start(go), .i_len(mlen), .i_bc(mbc_req),
		.i_mc(mmc_req), .o_byte(mbyte), .o_bc(mbc), .o_mc(mmc), .o_busy(busy));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	function automatic logic [9:0] idx(input logic [47:0] a, input logic [6:0] f, input logic [1:0] s);
		logic [15:0] c;
		logic [15:0] x;
		c = 16'h0000;
		for (int i = 47; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ a[i]) ? 16'h1021 : 16'h0000);
		x = a[47:32] ^ a[31:16] ^ a[15:0];
		if (s == 2'h1)
			return c[9:0] + {3'h0, f};
		if (s == 2'h2)
			return x[9:0] + {3'h0, f};
		return a[9:0] + {3'h0, f};
	endfunction
	task automatic frame(input logic [12:0] n, input logic b, input logic mc);
		int k;
		mlen = n;
		mbc_req = b;
		mmc_req = mc;
		go = 1'b1;
		tick;
		go = 1'b0;
		k = 0;
		while (busy === 1'b1 && k < 7000) begin
			tick;
			k++;
		end
		tick;
		tick;
	endtask
	task automatic look(input logic [47:0] da, input logic [47:0] sa, input logic [2:0] src,
		input logic err, input logic hs, input logic [8:0] e);
		int k;
		lk = '{da, sa, 7'h7f, src, err, hs};
		lk_req = 1'b1;
		tick;
		lk_req = 1'b0;
		k = 0;
		while (lk_v !== 1'b1 && k < 4) begin
			tick;
			k++;
		end
		chk("lookup valid", 64'h1, 64'(lk_v));
		chk("lookup result", 64'(e), 64'(res));
	endtask
	// --------------------------------------------------------------
	// Tests
	// --------------------------------------------------------------
	initial begin
		{rst_n, vlan_en, rsv_en, rate_wr, storm_mc, mt_wr, st_wr, learn, fb_wr, lk_req} = '0;
		{go, mbc_req, mmc_req, hsel, mt_way, lport, st_idx, selff, tail, lfid, mt_idx, mlen} = '0;
		{fwa, fra, rate, fwd, lmac, ment, sent, lk, error_cnt, comparisons} = '0;
		swmac = 48'h02aabbccddee;
		speed = 14'h2aaa;
		storm_en = 7'h01;
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		frame(13'd6250, 1'b1, 1'b0);
		chk("storm at rate", 64'h0, 64'(over));
		frame(13'd1, 1'b1, 1'b0);
		chk("storm over rate", 64'h1, 64'(over));
		repeat (200) tick;
		chk("storm new interval", 64'h0, 64'(over));
		rate = 20'h00004;
		rate_wr = 1'b1;
		tick;
		rate_wr = 1'b0;
		frame(13'd6, 1'b0, 1'b1);
		chk("multicast ignored", 64'h0, 64'(over));
		storm_mc = 1'b1;
		frame(13'd6, 1'b0, 1'b1);
		chk("multicast counted", 64'h1, 64'(over));
		storm_en = 7'h00;
		tick;
		tick;
		chk("storm disabled", 64'h0, 64'(over));
		$display("test storm done");
		fwa = 16'hffff;
		fwd = 32'hcafe0001;
		fb_wr = 1'b1;
		tick;
		fb_wr = 1'b0;
		fra = 16'hffff;
		tick;
		tick;
		chk("buffer top word", 64'hcafe0001, 64'(frd));
		chk("pause source", 64'(swmac), 64'(psa));
		tail = 7'h10;
		tick;
		tick;
		chk("host flags", 64'h25, 64'({hport, host_v, host_m, 1'b1}));
		look(48'h02000000abcd, SA, 3'h0, 1'b0, 1'b1, {2'h0, 7'h10});
		tail = 7'h30;
		tick;
		tick;
		chk("host conflict", 64'h1, 64'(host_m));
		selff = 7'h04;
		look(48'h02000000abcd, swmac, 3'h2, 1'b0, 1'b0, {2'h2, 7'h00});
		look(48'h02000000abcd, swmac, 3'h3, 1'b0, 1'b0, {2'h0, 7'h77});
		look(48'h02000000abcd, SA, 3'h0, 1'b1, 1'b0, {2'h2, 7'h00});
		$display("test filters done");
		for (int s = 0; s < 4; s++) begin
			hsel = 2'(s);
			mt_way = 2'(s);
			vlan_en = (s != 2);
			m = {36'h020012345, hsel, 10'h3f0};
			lfid = vlan_en ? 7'h7f : 7'h00;
			mt_idx = idx(m, lfid, hsel);
			ment = '{1'b1, lfid, m, 7'h04 << s};
			mt_wr = 1'b1;
			tick;
			mt_wr = 1'b0;
			look(m, SA, 3'h0, 1'b0, 1'b0, {2'h1, 7'h04 << s});
		end
		look(48'h020000005555, SA, 3'h0, 1'b0, 1'b0, {2'h0, 7'h7e});
		$display("test hashing done");
		lmac = 48'h020000000b0b;
		lfid = 7'h7f;
		lport = 3'h1;
		learn = 1'b1;
		tick;
		learn = 1'b0;
		tick;
		look(lmac, SA, 3'h0, 1'b0, 1'b0, {2'h1, 7'h02});
		st_idx = 4'h5;
		sent = '{1'b1, 7'h7f, lmac, 7'h08};
		st_wr = 1'b1;
		tick;
		st_wr = 1'b0;
		tick;
		look(lmac, SA, 3'h0, 1'b0, 1'b0, {2'h1, 7'h08});
		rsv_en = 1'b1;
		look(48'h0180c2000000, SA, 3'h0, 1'b0, 1'b0, {2'h1, 7'h40});
		look(48'h0180c2000001, SA, 3'h0, 1'b0, 1'b0, {2'h3, 7'h00});
		look(48'h0180c2000010, SA, 3'h0, 1'b0, 1'b0, {2'h1, 7'h7e});
		$display("test tables done");
		summarize;
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize;
	end
endmodule
`default_nettype wire
